// >>> fcs_cpu.sv
// CPU-side model issuing flash command and read bus cycles
`timescale 1ns/1ps
`default_nettype none
module fcs_cpu (
  // Clock
  input  wire logic       clk_sys,
  // Command bus
  output var  logic       bus_wr,
  output var  logic       bus_rd,
  output var  logic [9:0] bus_addr,
  output var  logic [7:0] bus_wdata,
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_rvalid
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 10'h000;
    bus_wdata = 8'h00;
  end
  // Idle lines show the inverse so stale values never look valid
  task automatic idle_bus;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
  // One write cycle: bus_wr, address and data held for one clock, then bus_wr low and idle lines
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk_sys);
    #1;
    bus_wr = 1'b0;
    idle_bus();
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    int n;
    d = 'x;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b1;
    bus_addr = a;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b0;
    idle_bus();
    for (n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      #1;
      if (bus_rvalid === 1'b1) begin
        d = bus_rdata;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> fcs_defs.vh
// Constants shared by the flash command sequencer and its array memory
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// ============================================================
// Command codes
`define FCS_CMD_READ_ARRAY   8'hFF
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM      8'h40
`define FCS_CMD_BLOCK_ERASE  8'h20
`define FCS_CMD_LOCK_PROGRAM 8'h77
`define FCS_CMD_LOCK_READ    8'h71
`define FCS_CMD_CONFIRM      8'hD0

// ============================================================
// Array geometry and erased value
`define FCS_ADDR_W     10
`define FCS_OFFS_W     7
`define FCS_NUM_DF_BLK 4
`define FCS_ERASED     8'hFF

// ============================================================
// Status byte layout
`define FCS_ST_READY     7
`define FCS_ST_SUSPENDED 6
`define FCS_ST_ERASE_ERR 5
`define FCS_ST_PROG_ERR  4
`define FCS_ST_LOCK      0

// ============================================================
// Operation timing in clock cycles and timing counter width in bits
`define FCS_PROG_CYC       16
`define FCS_ERASE_STEP_CYC 4
`define FCS_CNT_W          16

`endif

// >>> fcs_mem.v
// Byte-wide flash array model with registered read data
`timescale 1ns/1ps
`default_nettype none

module fcs_mem #(
  parameter ADDR_W = 10
) (
  // Clock
  input  wire              clk_sys,
  // Access port
  input  wire [ADDR_W-1:0] addr,
  input  wire              rd_en,
  input  wire              wr_en,
  input  wire [7:0]        wdata,
  output reg  [7:0]        rdata
);

  reg [7:0] mem_q [0:(1<<ADDR_W)-1];

  // Read data holds between reads so a read-modify-verify can use it later
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= mem_q[addr];
    end
  end

endmodule

`default_nettype wire

// >>> fcs_seq_chk_sva.sv
// Port-level assertion checker for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_seq_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Command bus
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_rvalid,
  // Control bits
  input wire logic       suspend_enable_bit,
  input wire logic       suspend_request_bit,
  // Status
  input wire logic [7:0] flash_status_reg,
  input wire logic       ready_flag,
  input wire logic       program_error_flag,
  input wire logic       erase_error_flag,
  input wire logic       suspended_flag,
  input wire logic       lock_state_flag,
  input wire logic       read_array_mode,
  input wire logic       ready_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Tracks an accepted first cycle of a two-cycle command
  logic       pend_q;
  logic [7:0] first_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pend_q  <= 1'b0;
      first_q <= 8'h00;
    end else if (bus_wr && ready_flag && !suspended_flag) begin
      pend_q <= !pend_q && (bus_wdata == 8'h40 || bus_wdata == 8'h20 ||
                            bus_wdata == 8'h77 || bus_wdata == 8'h71);
      if (!pend_q) begin
        first_q <= bus_wdata;
      end
    end
  end

  AST_STATUS_PACK: assert property (flash_status_reg == {ready_flag, suspended_flag,
    erase_error_flag, program_error_flag, 3'h0, lock_state_flag}) else $error("status byte");
  AST_RVALID: assert property (bus_rd |-> ##2 bus_rvalid)
    else $error("read answer late");
  AST_RVALID_CAUSE: assert property (bus_rvalid |-> $past(bus_rd, 2))
    else $error("read answer without request");
  AST_FF_MODE: assert property (bus_wr && bus_wdata == 8'hFF && ready_flag && !suspended_flag
    && !(pend_q && first_q == 8'h40) |=> read_array_mode) else $error("read-array not entered");
  AST_RA_HOLD: assert property (read_array_mode && !bus_wr && !suspended_flag
    |=> read_array_mode) else $error("read-array left without command");
  AST_CLEAR: assert property (bus_wr && bus_wdata == 8'h50 && ready_flag && !pend_q
    && !suspended_flag |=> !program_error_flag && !erase_error_flag) else $error("clear");
  AST_BUSY_BOUND: assert property ($fell(ready_flag) |-> ##[1:600] ready_flag)
    else $error("busy too long");
  AST_IRQ_CAUSE: assert property (ready_irq |-> $rose(ready_flag))
    else $error("interrupt without ready edge");
  AST_SUSP_STATE: assert property (suspended_flag |-> ready_flag && read_array_mode)
    else $error("suspend state");
  AST_SUSP_CAUSE: assert property ($rose(suspended_flag) |->
    $past(suspend_enable_bit && suspend_request_bit)) else $error("suspend without request");
  AST_ERR_HOLD: assert property (program_error_flag && !bus_wr |=> program_error_flag)
    else $error("program error lost");
endmodule

bind fcs_sequencer fcs_seq_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
  .bus_rvalid(bus_rvalid), .suspend_enable_bit(suspend_enable_bit),
  .suspend_request_bit(suspend_request_bit), .flash_status_reg(flash_status_reg),
  .ready_flag(ready_flag), .program_error_flag(program_error_flag),
  .erase_error_flag(erase_error_flag), .suspended_flag(suspended_flag),
  .lock_state_flag(lock_state_flag), .read_array_mode(read_array_mode), .ready_irq(ready_irq)
);
`default_nettype wire

// >>> fcs_sequencer.v
// Flash command interpreter and program/erase/lock sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.vh"

module fcs_sequencer #(
  parameter ADDR_W         = `FCS_ADDR_W,
  parameter OFFS_W         = `FCS_OFFS_W,
  parameter NUM_DF_BLK     = `FCS_NUM_DF_BLK,
  parameter PROG_CYC       = `FCS_PROG_CYC,
  parameter ERASE_STEP_CYC = `FCS_ERASE_STEP_CYC
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              nrst,
  // CPU command bus
  input  wire              bus_wr,
  input  wire              bus_rd,
  input  wire [ADDR_W-1:0] bus_addr,
  input  wire [7:0]        bus_wdata,
  output reg  [7:0]        bus_rdata,
  output reg               bus_rvalid,
  // Control bits
  input  wire              lock_disable_bit,
  input  wire              dataflash_a_rewrite_inhibit,
  input  wire              dataflash_b_rewrite_inhibit,
  input  wire              dataflash_c_rewrite_inhibit,
  input  wire              dataflash_d_rewrite_inhibit,
  input  wire              suspend_enable_bit,
  input  wire              suspend_request_bit,
  input  wire              ready_irq_enable,
  // Status
  output wire [7:0]        flash_status_reg,
  output reg               ready_flag,
  output reg               program_error_flag,
  output reg               erase_error_flag,
  output reg               suspended_flag,
  output reg               lock_state_flag,
  output reg               read_array_mode,
  output reg               ready_irq
);

  localparam BLK_W = ADDR_W - OFFS_W;
  localparam NBLK  = 1 << BLK_W;
  localparam CNT_W = `FCS_CNT_W;
  localparam [CNT_W-1:0] PROG_LAST = PROG_CYC - 1;
  localparam [CNT_W-1:0] STEP_LAST = ERASE_STEP_CYC - 1;
  localparam [OFFS_W-1:0] OFFS_LAST = {OFFS_W{1'b1}};
  localparam [OFFS_W-1:0] OFFS_ZERO = {OFFS_W{1'b0}};

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_CMD2  = 3'h1;
  localparam [2:0] S_PREAD = 3'h2;
  localparam [2:0] S_PWAIT = 3'h3;
  localparam [2:0] S_ERASE = 3'h4;
  localparam [2:0] S_SUSP  = 3'h5;
  localparam [2:0] S_LOCK  = 3'h6;

  // ============================================================
  // Decoding helpers
  function [BLK_W-1:0] blk_of;
    input [ADDR_W-1:0] a;
    begin
      blk_of = a[ADDR_W-1:OFFS_W];
    end
  endfunction

  function is_blk_start;
    input [ADDR_W-1:0] a;
    begin
      is_blk_start = (a[OFFS_W-1:0] == OFFS_ZERO);
    end
  endfunction

  // ============================================================
  // State
  reg [2:0]        state_reg;
  reg [7:0]        cmd_reg;
  reg [ADDR_W-1:0] first_addr_reg;
  reg [ADDR_W-1:0] op_addr_reg;
  reg [7:0]        op_data_reg;
  reg [CNT_W-1:0]  cnt_reg;
  reg [NBLK-1:0]   lock_bits_reg;
  reg              rd_p1_reg;
  reg              rd_arr_p1_reg;
  reg [7:0]        rd_status_reg;

  wire [7:0]       mem_rdata;
  wire [NBLK-1:0]  inhibit_map;
  wire [NBLK-1:0]  locked_map;
  wire [3:0]       df_inhibit;

  assign df_inhibit = {dataflash_d_rewrite_inhibit, dataflash_c_rewrite_inhibit,
                       dataflash_b_rewrite_inhibit, dataflash_a_rewrite_inhibit};

  // Data blocks have no lock bit; program blocks have no inhibit bit
  genvar gi;
  generate
    for (gi = 0; gi < NBLK; gi = gi + 1) begin : g_blk
      if (gi < NUM_DF_BLK) begin : g_df
        assign inhibit_map[gi] = df_inhibit[gi];
        assign locked_map[gi]  = 1'b0;
      end else begin : g_pa
        assign inhibit_map[gi] = 1'b0;
        // Lock disable masks the stored bit without changing it
        assign locked_map[gi]  = ~lock_disable_bit & ~lock_bits_reg[gi];
      end
    end
  endgenerate

  assign flash_status_reg = {ready_flag, suspended_flag, erase_error_flag,
                             program_error_flag, 3'h0, lock_state_flag};

  // ============================================================
  // Array port steering
  wire [BLK_W-1:0] bus_blk   = blk_of(bus_addr);
  wire [BLK_W-1:0] op_blk    = blk_of(op_addr_reg);
  wire             prog_done = (state_reg == S_PWAIT) && (cnt_reg == PROG_LAST);
  wire             susp_req  = suspend_enable_bit & suspend_request_bit;
  wire             step_tick = (state_reg == S_ERASE) && (cnt_reg == STEP_LAST) && !susp_req;
  wire             op_busy   = (state_reg == S_PREAD) || (state_reg == S_PWAIT) ||
                               (state_reg == S_ERASE) || (state_reg == S_LOCK);
  wire             arr_rd    = bus_rd && read_array_mode && !op_busy;
  // Bits can only be cleared by programming; verify catches a 0 that should be 1
  wire [7:0]       prog_val  = mem_rdata & op_data_reg;

  reg              mem_rd;
  reg              mem_wr;
  reg [7:0]        mem_wdata;
  reg [ADDR_W-1:0] mem_addr;

  always @* begin
    mem_addr  = op_busy ? op_addr_reg : bus_addr;
    mem_rd    = arr_rd || (state_reg == S_PREAD);
    mem_wr    = prog_done || step_tick;
    mem_wdata = step_tick ? `FCS_ERASED : prog_val;
  end

  fcs_mem #(
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .addr    (mem_addr),
    .rd_en   (mem_rd),
    .wr_en   (mem_wr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ============================================================
  // Read return path, two cycles after the request
  always @(posedge clk_sys) begin
    if (!nrst) begin
      rd_p1_reg     <= 1'b0;
      rd_arr_p1_reg <= 1'b0;
      rd_status_reg <= 8'h00;
      bus_rdata     <= 8'h00;
      bus_rvalid    <= 1'b0;
    end else begin
      rd_p1_reg     <= bus_rd;
      rd_arr_p1_reg <= arr_rd;
      rd_status_reg <= flash_status_reg;
      bus_rvalid    <= rd_p1_reg;
      if (rd_p1_reg) begin
        bus_rdata <= rd_arr_p1_reg ? mem_rdata : rd_status_reg;
      end
    end
  end

  // ============================================================
  // Command sequencer
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg          <= S_IDLE;
      cmd_reg            <= 8'h00;
      first_addr_reg     <= {ADDR_W{1'b0}};
      op_addr_reg        <= {ADDR_W{1'b0}};
      op_data_reg        <= 8'h00;
      cnt_reg            <= {CNT_W{1'b0}};
      lock_bits_reg      <= {NBLK{1'b1}};
      ready_flag         <= 1'b1;
      program_error_flag <= 1'b0;
      erase_error_flag   <= 1'b0;
      suspended_flag     <= 1'b0;
      lock_state_flag    <= 1'b1;
      read_array_mode    <= 1'b1;
      ready_irq          <= 1'b0;
    end else begin
      ready_irq <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (bus_wr) begin
            case (bus_wdata)
              `FCS_CMD_READ_ARRAY: begin
                read_array_mode <= 1'b1;
              end
              `FCS_CMD_CLEAR_STATUS: begin
                program_error_flag <= 1'b0;
                erase_error_flag   <= 1'b0;
              end
              `FCS_CMD_PROGRAM, `FCS_CMD_BLOCK_ERASE,
              `FCS_CMD_LOCK_PROGRAM, `FCS_CMD_LOCK_READ: begin
                cmd_reg         <= bus_wdata;
                first_addr_reg  <= bus_addr;
                read_array_mode <= 1'b0;
                state_reg       <= S_CMD2;
              end
              default: begin
                program_error_flag <= 1'b1;
                erase_error_flag   <= 1'b1;
                read_array_mode    <= 1'b0;
              end
            endcase
          end
        end
        S_CMD2: begin
          if (bus_wr) begin
            state_reg <= S_IDLE;
            cnt_reg   <= {CNT_W{1'b0}};
            if (bus_wdata == `FCS_CMD_READ_ARRAY && cmd_reg != `FCS_CMD_PROGRAM) begin
              // First cycle is dropped; program data FFh is still a byte to write
              read_array_mode <= 1'b1;
            end else begin
              case (cmd_reg)
                `FCS_CMD_PROGRAM: begin
                  if (bus_addr != first_addr_reg) begin
                    program_error_flag <= 1'b1;
                    erase_error_flag   <= 1'b1;
                  end else if (locked_map[bus_blk]) begin
                    program_error_flag <= 1'b1;
                  end else begin
                    op_addr_reg <= bus_addr;
                    op_data_reg <= bus_wdata;
                    ready_flag  <= 1'b0;
                    state_reg   <= S_PREAD;
                  end
                end
                `FCS_CMD_BLOCK_ERASE: begin
                  if (bus_wdata != `FCS_CMD_CONFIRM) begin
                    program_error_flag <= 1'b1;
                    erase_error_flag   <= 1'b1;
                  end else if (inhibit_map[bus_blk] || locked_map[bus_blk]) begin
                    erase_error_flag <= 1'b1;
                  end else begin
                    op_addr_reg <= {bus_blk, OFFS_ZERO};
                    ready_flag  <= 1'b0;
                    state_reg   <= S_ERASE;
                  end
                end
                `FCS_CMD_LOCK_PROGRAM: begin
                  if (bus_wdata != `FCS_CMD_CONFIRM || bus_addr != first_addr_reg ||
                      !is_blk_start(bus_addr)) begin
                    program_error_flag <= 1'b1;
                    erase_error_flag   <= 1'b1;
                  end else if (bus_blk >= NUM_DF_BLK) begin
                    op_addr_reg <= bus_addr;
                    ready_flag  <= 1'b0;
                    state_reg   <= S_LOCK;
                  end
                end
                default: begin
                  if (bus_wdata != `FCS_CMD_CONFIRM || !is_blk_start(bus_addr)) begin
                    program_error_flag <= 1'b1;
                    erase_error_flag   <= 1'b1;
                  end else begin
                    // Stored bit, regardless of lock disable
                    lock_state_flag <= lock_bits_reg[bus_blk];
                  end
                end
              endcase
            end
          end
        end
        S_PREAD: begin
          state_reg <= S_PWAIT;
        end
        S_PWAIT: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (prog_done) begin
            program_error_flag <= program_error_flag | (prog_val != op_data_reg);
            ready_flag         <= 1'b1;
            read_array_mode    <= 1'b1;
            ready_irq          <= ready_irq_enable;
            state_reg          <= S_IDLE;
          end
        end
        S_ERASE: begin
          if (susp_req) begin
            suspended_flag  <= 1'b1;
            ready_flag      <= 1'b1;
            read_array_mode <= 1'b1;
            ready_irq       <= ready_irq_enable;
            state_reg       <= S_SUSP;
          end else if (step_tick) begin
            cnt_reg <= {CNT_W{1'b0}};
            if (op_addr_reg[OFFS_W-1:0] == OFFS_LAST) begin
              lock_bits_reg[op_blk] <= 1'b1;
              // Writes always land, so the erase result is clean here
              erase_error_flag <= erase_error_flag;
              ready_flag       <= 1'b1;
              read_array_mode  <= 1'b1;
              ready_irq        <= ready_irq_enable;
              state_reg        <= S_IDLE;
            end else begin
              op_addr_reg <= op_addr_reg + 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_SUSP: begin
          // Only array reads are served while suspended; writes are dropped
          if (!susp_req) begin
            suspended_flag  <= 1'b0;
            ready_flag      <= 1'b0;
            read_array_mode <= 1'b0;
            state_reg       <= S_ERASE;
          end
        end
        S_LOCK: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == PROG_LAST) begin
            lock_bits_reg[op_blk] <= 1'b0;
            ready_flag            <= 1'b1;
            state_reg             <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> fcs_sequencer_test.sv
// Self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module fcs_sequencer_test;
  logic       clk_sys, nrst, bus_wr, bus_rd, bus_rvalid, lock_dis, sus_en, sus_req, irq_en;
  logic       ready_flag, program_error_flag, erase_error_flag, suspended_flag;
  logic       lock_state_flag, read_array_mode, ready_irq;
  logic [9:0] bus_addr, a;
  logic [7:0] bus_wdata, bus_rdata, flash_status_reg, d;
  logic [3:0] inh;
  logic [7:0] mem_ref [0:1023];
  logic [7:0] bad_tab [0:4] = '{8'h20, 8'h77, 8'h71, 8'h25, 8'h40};
  int         miscompares = 0, num_checks = 0, irq_cnt = 0, b, i, n, seed;

  fcs_cpu u_cpu (.clk_sys(clk_sys), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
  // Short operation counts keep erase near 128 cycles
  fcs_sequencer #(.PROG_CYC(2), .ERASE_STEP_CYC(1)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .lock_disable_bit(lock_dis), .dataflash_a_rewrite_inhibit(inh[0]),
    .dataflash_b_rewrite_inhibit(inh[1]), .dataflash_c_rewrite_inhibit(inh[2]),
    .dataflash_d_rewrite_inhibit(inh[3]), .suspend_enable_bit(sus_en),
    .suspend_request_bit(sus_req), .ready_irq_enable(irq_en),
    .flash_status_reg(flash_status_reg), .ready_flag(ready_flag),
    .program_error_flag(program_error_flag), .erase_error_flag(erase_error_flag),
    .suspended_flag(suspended_flag), .lock_state_flag(lock_state_flag),
    .read_array_mode(read_array_mode), .ready_irq(ready_irq));

  always @(posedge clk_sys) if (ready_irq === 1'b1) irq_cnt++;

  function automatic logic [7:0] prog_val(input logic [7:0] old, input logic [7:0] wd);
    return old & wd;
  endfunction

  task automatic op2(input logic [9:0] a1, input logic [7:0] c1, input logic [9:0] a2,
                     input logic [7:0] c2, input bit busy);
    int k;
    u_cpu.wr(a1, c1);
    u_cpu.wr(a2, c2);
    @(posedge clk_sys);
    #1;
    if (busy) `CHK("ready_busy", 1'b0, ready_flag)
    for (k = 0; k < 600 && ready_flag !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    // Let the completion pulse reach the interrupt counter
    @(posedge clk_sys);
    #1;
    `CHK("ready_done", 1'b1, ready_flag)
  endtask

  task automatic chk_rd(input logic [9:0] ra);
    logic [7:0] v;
    u_cpu.rd(ra, v);
    `CHK("rdata", mem_ref[ra], v)
  endtask

  task automatic fill_ff(input int fb);
    for (int j = 0; j < 128; j++) mem_ref[{fb[2:0], j[6:0]}] = 8'hFF;
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #80000;
    miscompares++;
    end_sim();
  end

  initial begin
    {nrst, lock_dis, sus_en, sus_req, irq_en, inh} = 9'h000;
    seed = $urandom(84258);
    repeat (20) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    `CHK("status_rst", 8'h81, flash_status_reg)
    `CHK("ra_rst", 1'b1, read_array_mode)
    // The array is not cleared by reset, so every block is erased first
    for (b = 0; b < 8; b++) begin
      irq_en = 1'($urandom);
      a = {b[2:0], 7'($urandom)};
      n = irq_cnt;
      op2(a, 8'h20, a, 8'hD0, 1'b1);
      fill_ff(b);
      `CHK("irq_erase", n + int'(irq_en), irq_cnt)
      chk_rd({b[2:0], 7'h7F});
    end
    for (i = 0; i < 24; i++) begin
      irq_en = 1'($urandom);
      do a = 10'($urandom); while (mem_ref[a] !== 8'hFF);
      d = 8'($urandom);
      n = irq_cnt;
      op2(a, 8'h40, a, d, 1'b1);
      mem_ref[a] = prog_val(mem_ref[a], d);
      `CHK("irq_prog", n + int'(irq_en), irq_cnt)
      `CHK("prog_err", 1'b0, program_error_flag)
      chk_rd(a);
      chk_rd(10'($urandom));
    end
    for (i = 0; i < 5; i++) begin
      u_cpu.wr(10'h200, bad_tab[i]);
      if (i < 3) u_cpu.wr(10'h200, 8'h55);
      else if (i == 4) u_cpu.wr(10'h201, 8'h00);
      `CHK("seq_err", 8'hB1, flash_status_reg)
      u_cpu.wr(10'h000, 8'h50);
      `CHK("cleared", 8'h81, flash_status_reg)
    end
    u_cpu.wr(10'h200, 8'h20);
    u_cpu.wr(10'h200, 8'hFF);
    `CHK("ff_second", 8'h81, flash_status_reg)
    `CHK("ff_mode", 1'b1, read_array_mode)
    chk_rd(10'h201);
    for (b = 0; b < 4; b++) begin
      inh = 4'h1 << b;
      a = {b[2:0], 7'($urandom)};
      op2(a, 8'h20, a, 8'hD0, 1'b0);
      `CHK("inhibit", 8'hA1, flash_status_reg)
      u_cpu.wr(a, 8'h50);
      u_cpu.wr(a, 8'hFF);
      chk_rd(a);
    end
    inh = 4'h0;
    op2(10'h280, 8'h77, 10'h280, 8'hD0, 1'b1);
    op2(10'h000, 8'h71, 10'h280, 8'hD0, 1'b0);
    `CHK("locked", 1'b0, lock_state_flag)
    do a = {3'h5, 7'($urandom)}; while (mem_ref[a] !== 8'hFF);
    op2(a, 8'h40, a, 8'h00, 1'b0);
    `CHK("lock_prog", 8'h90, flash_status_reg)
    u_cpu.wr(a, 8'h50);
    op2(a, 8'h20, a, 8'hD0, 1'b0);
    `CHK("lock_erase", 8'hA0, flash_status_reg)
    u_cpu.wr(a, 8'h50);
    u_cpu.wr(a, 8'hFF);
    chk_rd(a);
    lock_dis = 1'b1;
    op2(a, 8'h40, a, 8'h3C, 1'b1);
    mem_ref[a] = prog_val(mem_ref[a], 8'h3C);
    `CHK("unlock_prog", 8'h80, flash_status_reg)
    chk_rd(a);
    op2(10'h000, 8'h71, 10'h280, 8'hD0, 1'b0);
    `CHK("lock_kept", 1'b0, lock_state_flag)
    op2(a, 8'h20, a, 8'hD0, 1'b1);
    fill_ff(5);
    chk_rd(a);
    lock_dis = 1'b0;
    op2(10'h000, 8'h71, 10'h280, 8'hD0, 1'b0);
    `CHK("lock_erased", 1'b1, lock_state_flag)
    {sus_en, irq_en} = 2'b11;
    n = irq_cnt;
    u_cpu.wr(10'h300, 8'h20);
    u_cpu.wr(10'h300, 8'hD0);
    repeat (10) @(posedge clk_sys);
    #1;
    sus_req = 1'b1;
    for (i = 0; i < 50 && suspended_flag !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    `CHK("suspended", 8'hC1, flash_status_reg)
    `CHK("irq_susp", n + 1, irq_cnt)
    chk_rd(10'h010);
    sus_req = 1'b0;
    op2(10'h000, 8'h00, 10'h000, 8'h00, 1'b0);
    fill_ff(6);
    `CHK("irq_resume", n + 2, irq_cnt)
    u_cpu.wr(10'h000, 8'h50);
    u_cpu.wr(10'h000, 8'hFF);
    chk_rd(10'h35A);
    end_sim();
  end
endmodule
`default_nettype wire
